// ---- fpu_state_unit.sv ----
// fpu state unit: state reload/dump over a 16-bit memory port, exponent adjust and sine
// assumes mode, privilege and segment inputs come from the integer core on clk_i
// Functional notes
// RULE1 - reload op restores environment and stack, 94/108 bytes
// RULE2 - environment holds control, status, tag, both pointers
// RULE3 - environment is 14 or 28 bytes by attribute
// RULE4 - whole image is 94 or 108 bytes
// RULE5 - virtual-8086 mode uses the real-mode layout
// RULE6 - eight stack entries follow, top first, 80 bytes
// RULE7 - software reloads in the mode it dumped
// RULE8 - condition flags after reload equal loaded image
// RULE9 - loaded unmasked flagged exception raises error condition
// RULE10 - dump writes whole state then reinitialises unit
// RULE11 - waiting dump checks pending error, no-wait skips
// RULE12 - dump leaves all condition flags cleared
// RULE13 - dump waits until outstanding unit work finishes
// RULE14 - software waits before reading dumped image
// RULE15 - absent or task-switched bit faults every op
// RULE16 - real mode operand past 0ffffh faults 13
// RULE17 - protected: unwritable gp fault, unaligned cpl3 ac
// RULE18 - exponent adjust adds second entry to top exponent
// RULE19 - factor chopped toward zero, unlimited, zero keeps top
// RULE20 - in-range sine replaces top, clears incomplete flag
// RULE21 - out-of-range sine sets flag, top unchanged
// RULE22 - sine checks interrupts each step and aborts
//
// The address map and strobed register access were decided locally.
`timescale 1ns/10ps
`include "fpu_unit_regs.svh"

module fpu_state_unit
	import fpu_unit_pkg::*;
#(
	parameter logic [3:0] POLY_TERMS = 4'h9 // sine series depth, at most nine
)(
	input wire logic clk_i, // 10 MHz core clock
	input wire logic rstn_i, // asynchronous reset, active low
	input wire logic [7:0] reg_addr_i, // register byte address
	input wire logic [31:0] reg_wdata_i, // register write data
	input wire logic reg_we_i, // register write strobe
	input wire logic reg_re_i, // register read strobe
	output logic [31:0] reg_rdata_o, // read data, cycle after the strobe
	input wire logic prot_mode_i, // protected mode
	input wire logic v86_mode_i, // virtual-8086 mode
	input wire logic [1:0] cpl_i, // current privilege level
	input wire logic align_check_i, // alignment checking enabled
	input wire logic wide_code_attr_i, // 32-bit code segment attribute
	input wire logic seg_writable_i, // destination segment writable
	input wire logic coproc_absent_bit_i, // control_reg_zero absent bit
	input wire logic task_switched_bit_i, // control_reg_zero task switched bit
	input wire logic unit_busy_i, // other unit work still outstanding
	input wire logic intr_pending_i, // interrupt waiting for service
	output mem_req_t mem_o, // memory word request, held until ack
	input wire logic mem_ack_i, // memory accepted or returned the word
	input wire logic [15:0] mem_rdata_i, // memory read word
	output fault_t fault_o, // fault pulse with vector
	output logic fp_error_o, // unmasked error condition pending
	output logic busy_o, // an operation is in progress
	output logic done_o // operation finished pulse
);

	state_t q, d;

	function automatic logic [63:0] mulq(input logic [63:0] x, input logic [63:0] y);
		logic [127:0] pr;
		pr = x * y;
		return pr[123:60];
	endfunction : mulq

	// reciprocal of (2k)(2k+1) for the nested sine series
	function automatic logic [63:0] coef(input logic [3:0] k);
		case (k)
			4'h1: coef = `Q_ONE / 64'h6;
			4'h2: coef = `Q_ONE / 64'h14;
			4'h3: coef = `Q_ONE / 64'h2a;
			4'h4: coef = `Q_ONE / 64'h48;
			4'h5: coef = `Q_ONE / 64'h6e;
			4'h6: coef = `Q_ONE / 64'h9c;
			4'h7: coef = `Q_ONE / 64'hd2;
			4'h8: coef = `Q_ONE / 64'h110;
			4'h9: coef = `Q_ONE / 64'h156;
			default: coef = 64'h0;
		endcase
	endfunction : coef

	function automatic logic [5:0] env_words(input logic wide);
		return wide ? `ENV_WIDE_W : `ENV_NARROW_W; // RULE3
	endfunction : env_words

	function automatic logic [15:0] dump_word(input state_t s, input logic [5:0] k);
		logic [5:0] envn;
		logic [5:0] slot;
		logic [5:0] j;
		logic [2:0] i;
		logic [2:0] w;
		logic hi;
		ext_t e;
		envn = env_words(s.wide);
		slot = s.wide ? {1'b0, k[5:1]} : k;
		hi = s.wide & k[0];
		j = 6'(k - envn);
		i = 3'(j / 6'h5);
		w = 3'(j % 6'h5);
		e = s.stk[3'(s.sw[`SW_TOP_LSB +: 3] + i)]; // RULE6
		dump_word = 16'h0;
		if (k < envn) begin // RULE2 RULE5
			case (slot)
				6'h0: dump_word = hi ? 16'h0 : s.cw;
				6'h1: dump_word = hi ? 16'h0 : s.sw;
				6'h2: dump_word = hi ? 16'h0 : s.tw;
				6'h3: dump_word = hi ? (s.realish ? 16'h0 : s.fip[31:16]) : s.fip[15:0];
				6'h4: dump_word = hi ? (s.realish ? 16'h0 : {5'h0, s.fop})
					: (s.realish ? {s.fip[19:16], 1'b0, s.fop} : s.fcs);
				6'h5: dump_word = hi ? (s.realish ? 16'h0 : s.fdp[31:16]) : s.fdp[15:0];
				6'h6: dump_word = hi ? 16'h0 : (s.realish ? {s.fdp[19:16], 12'h0} : s.fds);
				default: dump_word = 16'h0;
			endcase
		end else begin
			case (w)
				3'h0: dump_word = e.man[15:0];
				3'h1: dump_word = e.man[31:16];
				3'h2: dump_word = e.man[47:32];
				3'h3: dump_word = e.man[63:48];
				default: dump_word = {e.sign, e.exp};
			endcase
		end
	endfunction : dump_word

	function automatic state_t load_word(input state_t s, input logic [5:0] k, input logic [15:0] v);
		logic [5:0] envn;
		logic [5:0] slot;
		logic [5:0] j;
		logic [2:0] i;
		logic [2:0] w;
		logic [2:0] ph;
		logic hi;
		envn = env_words(s.wide);
		slot = s.wide ? {1'b0, k[5:1]} : k;
		hi = s.wide & k[0];
		j = 6'(k - envn);
		i = 3'(j / 6'h5);
		w = 3'(j % 6'h5);
		// top is taken from the status word already reloaded earlier in the image
		ph = 3'(s.sw[`SW_TOP_LSB +: 3] + i);
		load_word = s;
		if (k < envn) begin // RULE1 RULE2 RULE5
			case (slot)
				6'h0: if (!hi) load_word.cw = v;
				6'h1: if (!hi) load_word.sw = v; // RULE8
				6'h2: if (!hi) load_word.tw = v;
				6'h3: begin
					if (!hi) load_word.fip[15:0] = v;
					else if (!s.realish) load_word.fip[31:16] = v;
				end
				6'h4: begin
					if (hi) begin
						if (!s.realish) load_word.fop = v[10:0];
					end else if (s.realish) begin
						load_word.fip[31:16] = {12'h0, v[15:12]};
						load_word.fop = v[10:0];
					end else begin
						load_word.fcs = v;
					end
				end
				6'h5: begin
					if (!hi) load_word.fdp[15:0] = v;
					else if (!s.realish) load_word.fdp[31:16] = v;
				end
				6'h6: begin
					if (!hi && s.realish) load_word.fdp[31:16] = {12'h0, v[15:12]};
					else if (!hi) load_word.fds = v;
				end
				default: load_word.cw = s.cw;
			endcase
		end else begin
			case (w) // RULE6
				3'h0: load_word.stk[ph].man[15:0] = v;
				3'h1: load_word.stk[ph].man[31:16] = v;
				3'h2: load_word.stk[ph].man[47:32] = v;
				3'h3: load_word.stk[ph].man[63:48] = v;
				default: {load_word.stk[ph].sign, load_word.stk[ph].exp} = v;
			endcase
		end
	endfunction : load_word

	logic [2:0] top;
	ext_t a, b, res;
	op_t op_dec;
	logic [7:0] vec;
	logic [32:0] span;
	logic [16:0] n;
	logic [17:0] ne;
	logic [63:0] rr, lsw, y;
	logic [5:0] nidx, pos;
	logic [14:0] sh;

	always_comb begin
		d = q;
		top = q.sw[`SW_TOP_LSB +: 3];
		a = q.stk[top];
		b = q.stk[3'(top + 3'h1)];
		res = a;
		op_dec = OP_NONE;
		vec = `VEC_NONE;
		span = 33'h0;
		n = 17'h0;
		ne = 18'h0;
		rr = 64'h0;
		lsw = 64'h0;
		y = 64'h0;
		nidx = 6'(q.idx + 6'h1);
		pos = 6'h0;
		sh = 15'h0;
		d.done = 1'b0;
		d.fault = '0;
		d.rdata = 32'h0;
		if (reg_re_i) begin
			case (reg_addr_i)
				`REG_OFFSET: d.rdata = q.off;
				`REG_STATUS: d.rdata = {15'h0, q.bad_cmd, q.last_vec, 5'h0, q.sw[`SW_ES],
					q.aborted, q.fsm != S_IDLE};
				`REG_FCW: d.rdata = {16'h0, q.cw};
				`REG_FSW: d.rdata = {16'h0, q.sw};
				`REG_FTW: d.rdata = {16'h0, q.tw};
				`REG_SEL: d.rdata = {29'h0, q.sel};
				`REG_ST_LO: d.rdata = q.stk[3'(top + q.sel)].man[31:0];
				`REG_ST_MID: d.rdata = q.stk[3'(top + q.sel)].man[63:32];
				`REG_ST_HI: d.rdata = {16'h0, q.stk[3'(top + q.sel)].sign,
					q.stk[3'(top + q.sel)].exp};
				default: d.rdata = 32'h0;
			endcase
		end
		unique case (q.fsm)
			S_IDLE: begin
				// register writes only land while idle so no operation sees a moving operand
				if (reg_we_i) begin
					case (reg_addr_i)
						`REG_OFFSET: d.off = reg_wdata_i;
						`REG_FCW: d.cw = reg_wdata_i[15:0];
						`REG_FSW: d.sw = reg_wdata_i[15:0];
						`REG_FTW: d.tw = reg_wdata_i[15:0];
						`REG_SEL: d.sel = reg_wdata_i[2:0];
						`REG_ST_LO: d.stk[3'(top + q.sel)].man[31:0] = reg_wdata_i;
						`REG_ST_MID: d.stk[3'(top + q.sel)].man[63:32] = reg_wdata_i;
						`REG_ST_HI: {d.stk[3'(top + q.sel)].sign, d.stk[3'(top + q.sel)].exp} =
							reg_wdata_i[15:0];
						default: d.off = q.off;
					endcase
				end
				if (reg_we_i && reg_addr_i == `REG_CMD) begin
					if (reg_wdata_i[15:0] == `OPC_SCALE) op_dec = OP_SCALE; // RULE18
					else if (reg_wdata_i[15:0] == `OPC_SINE) op_dec = OP_SINE; // RULE20
					else if (reg_wdata_i[15:8] == `OPC_RELOAD_PRI && reg_wdata_i[5:3] == `OPC_RELOAD_REG)
						op_dec = OP_RELOAD; // RULE1
					else if (reg_wdata_i[15:8] == `OPC_DUMP_PRI && reg_wdata_i[5:3] == `OPC_DUMP_REG)
						op_dec = reg_wdata_i[`CMD_WAIT_BIT] ? OP_DUMP_WAIT : OP_DUMP_NOWAIT; // RULE10
					d.bad_cmd = (op_dec == OP_NONE);
					d.aborted = 1'b0;
					d.op = op_dec;
					d.wide = wide_code_attr_i;
					d.realish = !prot_mode_i || v86_mode_i; // RULE5
					span = {1'b0, q.off} +
						(wide_code_attr_i ? `IMG_WIDE_BYTES : `IMG_NARROW_BYTES) - 33'h1; // RULE4
					if (coproc_absent_bit_i || task_switched_bit_i) vec = `VEC_NM; // RULE15
					else if (op_dec == OP_DUMP_WAIT && q.sw[`SW_ES]) vec = `VEC_MF; // RULE11
					else if (op_dec == OP_RELOAD || op_dec == OP_DUMP_WAIT || op_dec == OP_DUMP_NOWAIT) begin
						if (d.realish && span > `REAL_LIMIT) vec = `VEC_GP; // RULE16
						else if (!d.realish && op_dec != OP_RELOAD && !seg_writable_i) vec = `VEC_GP; // RULE17
						else if (prot_mode_i && cpl_i == 2'h3 && align_check_i &&
							(wide_code_attr_i ? q.off[1:0] != 2'h0 : q.off[0])) vec = `VEC_AC; // RULE17
					end
					d.last_vec = vec;
					if (op_dec != OP_NONE) begin
						if (vec != `VEC_NONE) begin
							d.fault.valid = 1'b1;
							d.fault.vec = vec;
							d.done = 1'b1;
						end else begin
							case (op_dec)
								OP_SCALE: begin
									// RULE19
									if (b.exp < `EXP_BIAS) n = 17'h0;
									else if (b.exp >= 15'(`EXP_BIAS + 15'h10)) n = 17'h10000;
									else n = 17'(b.man >> 15'(15'h3f - (b.exp - `EXP_BIAS)));
									if (n != 17'h0 && a.exp != 15'h0 && a.exp != `EXP_MAX) begin
										ne = b.sign ? 18'({3'h0, a.exp} - {1'b0, n})
											: 18'({3'h0, a.exp} + {1'b0, n}); // RULE18
										if (!ne[17] && ne >= {3'h0, `EXP_MAX}) begin
											res.exp = `EXP_MAX;
											res.man = 64'h8000_0000_0000_0000;
										end else if (ne[17] || ne == 18'h0) begin
											res.exp = 15'h0;
											res.man = 64'h0;
										end else begin
											res.exp = ne[14:0];
										end
									end
									d.stk[top] = res;
									d.sw[`SW_C1] = 1'b0;
									d.done = 1'b1;
								end
								OP_SINE: begin
									if (a.exp >= `SINE_LIMIT_EXP) begin
										d.sw[`SW_C2] = 1'b1; // RULE21
										d.done = 1'b1;
									end else if (a.exp < `TINY_EXP) begin
										// sine equals the argument to full precision here
										d.sw[`SW_C2] = 1'b0; // RULE20
										d.done = 1'b1;
									end else begin
										d.neg = a.sign;
										if (a.exp >= `DIRECT_EXP) begin
											d.r = 64'h0;
											d.cnt = 7'h40;
										end else begin
											sh = 15'(`DIRECT_EXP - a.exp);
											d.r = a.man >> sh;
											d.cnt = 7'h0;
										end
										d.fsm = S_REDUCE;
									end
								end
								OP_RELOAD: begin
									d.idx = 6'h0;
									d.mem = '{req: 1'b1, we: 1'b0, addr: q.off, wdata: 16'h0};
									d.fsm = S_XFER;
								end
								default: d.fsm = S_DRAIN;
							endcase
						end
					end
				end
			end
			S_DRAIN: begin
				if (!unit_busy_i) begin // RULE13
					d.idx = 6'h0;
					d.mem = '{req: 1'b1, we: 1'b1, addr: q.off, wdata: dump_word(q, 6'h0)};
					d.fsm = S_XFER;
				end
			end
			S_XFER: begin
				if (mem_ack_i) begin
					if (q.op == OP_RELOAD) d = load_word(d, q.idx, mem_rdata_i); // RULE1
					if (nidx == 6'(env_words(q.wide) + `STACK_W)) begin // RULE4
						d.mem = '0;
						d.done = 1'b1;
						d.fsm = S_IDLE;
						if (q.op == OP_RELOAD) begin
							// RULE9
							d.sw[`SW_ES] = |(d.sw[5:0] & ~d.cw[5:0]);
							d.sw[`SW_BUSY] = d.sw[`SW_ES];
						end else begin
							d.cw = `CW_INIT; // RULE10
							d.sw = `SW_INIT; // RULE12
							d.tw = `TW_INIT;
							d.fip = 32'h0;
							d.fcs = 16'h0;
							d.fdp = 32'h0;
							d.fds = 16'h0;
							d.fop = 11'h0;
						end
					end else begin
						d.idx = nidx;
						d.mem.addr = q.off + {25'h0, nidx, 1'b0};
						d.mem.wdata = dump_word(q, nidx);
					end
				end
			end
			S_REDUCE: begin
				// one bit of the argument per cycle, modulo two pi, so long reductions stay abortable
				lsw = 64'h1 << 15'(a.exp - `DIRECT_EXP);
				if (intr_pending_i) begin // RULE22
					d.aborted = 1'b1;
					d.done = 1'b1;
					d.fsm = S_IDLE;
				end else if (q.cnt != 7'h0) begin
					rr = {q.r[62:0], 1'b0} + (a.man[6'(q.cnt - 7'h1)] ? lsw : 64'h0);
					if (rr >= `Q_TWO_PI) rr = rr - `Q_TWO_PI;
					if (rr >= `Q_TWO_PI) rr = rr - `Q_TWO_PI;
					d.r = rr;
					d.cnt = 7'(q.cnt - 7'h1);
				end else if (q.r >= `Q_TWO_PI) begin
					d.r = q.r - `Q_TWO_PI;
				end else begin
					rr = q.r;
					if (rr >= `Q_PI) begin
						rr = rr - `Q_PI;
						d.neg = !q.neg;
					end
					if (rr > `Q_HALF_PI) rr = `Q_PI - rr;
					d.r = rr;
					d.x2 = mulq(rr, rr);
					d.p = `Q_ONE;
					d.k = POLY_TERMS;
					d.ph = 1'b0;
					d.fsm = S_POLY;
				end
			end
			S_POLY: begin
				if (intr_pending_i) begin // RULE22
					d.aborted = 1'b1;
					d.done = 1'b1;
					d.fsm = S_IDLE;
				end else if (!q.ph) begin
					d.t = mulq(q.x2, coef(q.k));
					d.ph = 1'b1;
				end else begin
					d.p = `Q_ONE - mulq(q.t, q.p);
					d.ph = 1'b0;
					d.k = 4'(q.k - 4'h1);
					if (q.k == 4'h1) d.fsm = S_ROUND;
				end
			end
			S_ROUND: begin
				y = mulq(q.r, q.p);
				for (int i = 0; i < 64; i++) begin
					if (y[i]) pos = 6'(i);
				end
				res.sign = q.neg;
				if (y == 64'h0) begin
					res.exp = 15'h0;
					res.man = 64'h0;
				end else begin
					res.exp = 15'(`EXP_BIAS + {9'h0, pos} - `EXP_FRAC_POS);
					res.man = y << (6'h3f - pos);
				end
				d.stk[top] = res; // RULE20
				d.sw[`SW_C2] = 1'b0;
				d.sw[`SW_C1] = 1'b0;
				d.done = 1'b1;
				d.fsm = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			q <= '0;
			q.fsm <= S_IDLE;
			q.op <= OP_NONE;
			q.cw <= `CW_INIT;
			q.sw <= `SW_INIT;
			q.tw <= `TW_INIT;
		end else begin
			q <= d;
		end
	end

	assign reg_rdata_o = q.rdata;
	assign mem_o = q.mem;
	assign fault_o = q.fault;
	assign fp_error_o = q.sw[`SW_ES];
	assign busy_o = q.fsm != S_IDLE;
	assign done_o = q.done;

endmodule : fpu_state_unit

// ---- fpu_unit_regs.svh ----
// register offsets, field positions, reset values and constants of the fpu state unit
// assumes byte addresses on an 8-bit register port with 32-bit data words
`ifndef FPU_UNIT_REGS_SVH
`define FPU_UNIT_REGS_SVH

`define REG_CMD 8'h00
`define REG_OFFSET 8'h04
`define REG_STATUS 8'h08
`define REG_FCW 8'h0c
`define REG_FSW 8'h10
`define REG_FTW 8'h14
`define REG_SEL 8'h18
`define REG_ST_LO 8'h1c
`define REG_ST_MID 8'h20
`define REG_ST_HI 8'h24

`define SW_ES 7
`define SW_C0 8
`define SW_C1 9
`define SW_C2 10
`define SW_TOP_LSB 11
`define SW_C3 14
`define SW_BUSY 15
`define CMD_WAIT_BIT 16

`define CW_INIT 16'h037f
`define SW_INIT 16'h0000
`define TW_INIT 16'hffff

`define OPC_SCALE 16'hd9fd
`define OPC_SINE 16'hd9fe
`define OPC_RELOAD_PRI 8'hdb
`define OPC_RELOAD_REG 3'h4
`define OPC_DUMP_PRI 8'hdd
`define OPC_DUMP_REG 3'h6

`define EXP_BIAS 15'h3fff
`define EXP_MAX 15'h7fff
`define SINE_LIMIT_EXP 15'h403e
`define TINY_EXP 15'h3fe1
`define DIRECT_EXP 15'h4002
`define EXP_FRAC_POS 15'h003c

`define Q_ONE 64'h1000_0000_0000_0000
`define Q_PI 64'h3243_f6a8_885a_308d
`define Q_HALF_PI 64'h1921_fb54_4442_d184
`define Q_TWO_PI 64'h6487_ed51_10b4_611a

`define ENV_NARROW_W 6'h07
`define ENV_WIDE_W 6'h0e
`define STACK_W 6'h28
`define IMG_NARROW_BYTES 33'h0_0000_005e
`define IMG_WIDE_BYTES 33'h0_0000_006c
`define REAL_LIMIT 33'h0_0000_ffff

`define VEC_NONE 8'h00
`define VEC_NM 8'h07
`define VEC_GP 8'h0d
`define VEC_MF 8'h10
`define VEC_AC 8'h11

`endif

// ---- fpu_unit_pkg.sv ----
// types of the fpu state unit: states, operations, carriers and the state record
// assumes fpu_unit_regs.svh for all numeric constants
package fpu_unit_pkg;

	typedef enum logic [5:0] {
		S_IDLE = 6'b000001,
		S_DRAIN = 6'b000010,
		S_XFER = 6'b000100,
		S_REDUCE = 6'b001000,
		S_POLY = 6'b010000,
		S_ROUND = 6'b100000
	} fsm_t;

	typedef enum logic [2:0] {
		OP_NONE = 3'h0,
		OP_RELOAD = 3'h1,
		OP_DUMP_WAIT = 3'h2,
		OP_DUMP_NOWAIT = 3'h3,
		OP_SCALE = 3'h4,
		OP_SINE = 3'h5
	} op_t;

	typedef struct packed {
		logic sign;
		logic [14:0] exp;
		logic [63:0] man;
	} ext_t;

	typedef struct packed {
		logic req;
		logic we;
		logic [31:0] addr;
		logic [15:0] wdata;
	} mem_req_t;

	typedef struct packed {
		logic valid;
		logic [7:0] vec;
	} fault_t;

	typedef struct packed {
		fsm_t fsm;
		op_t op;
		logic wide;
		logic realish;
		logic [5:0] idx;
		logic [31:0] off;
		logic [15:0] cw;
		logic [15:0] sw;
		logic [15:0] tw;
		logic [31:0] fip;
		logic [15:0] fcs;
		logic [31:0] fdp;
		logic [15:0] fds;
		logic [10:0] fop;
		ext_t [7:0] stk;
		logic [2:0] sel;
		logic [31:0] rdata;
		mem_req_t mem;
		fault_t fault;
		logic [7:0] last_vec;
		logic done;
		logic aborted;
		logic bad_cmd;
		logic [63:0] r;
		logic [63:0] x2;
		logic [63:0] t;
		logic [63:0] p;
		logic [6:0] cnt;
		logic [3:0] k;
		logic ph;
		logic neg;
	} state_t;

endpackage : fpu_unit_pkg

// ---- fpu_state_chk_sva.sv ----
// assertions on the ports of the fpu state unit
// assumes a bind from the bench and the regs header on the include path
`timescale 1ns/10ps
`include "fpu_unit_regs.svh"
module fpu_state_chk
	import fpu_unit_pkg::*;
(
	input wire logic clk_i, // clock
	input wire logic rstn_i, // reset, active low
	input wire logic [7:0] reg_addr_i, // register address
	input wire logic [31:0] reg_wdata_i, // write data
	input wire logic reg_we_i, // write strobe
	input wire logic reg_re_i, // read strobe
	input wire logic [31:0] reg_rdata_o, // read data
	input wire logic coproc_absent_bit_i, // absent bit
	input wire logic task_switched_bit_i, // task switched bit
	input wire logic unit_busy_i, // outstanding unit work
	input wire mem_req_t mem_o, // memory request
	input wire logic mem_ack_i, // memory ack
	input wire fault_t fault_o, // fault pulse
	input wire logic busy_o, // busy level
	input wire logic done_o // done pulse
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	sequence s_cmd(logic [15:0] opc, logic nm);
		reg_we_i && reg_addr_i == `REG_CMD && reg_wdata_i[15:0] == opc && !busy_o
			&& (coproc_absent_bit_i || task_switched_bit_i) == nm;
	endsequence
	sequence s_word_step;
		mem_o.req && mem_ack_i ##1 mem_o.req;
	endsequence
	a_rdata_idle: assert property (!reg_re_i |=> reg_rdata_o == 32'h0)
		else $error("read data not zero outside a read");
	a_done_pulse: assert property (done_o |=> !done_o)
		else $error("done longer than one cycle");
	a_fault_pulse: assert property (fault_o.valid |-> done_o ##1 !fault_o.valid)
		else $error("fault pulse malformed");
	a_req_hold: assert property (mem_o.req && !mem_ack_i |=> mem_o.req && $stable(mem_o))
		else $error("memory request changed before ack");
	a_addr_step: assert property (s_word_step |-> mem_o.addr == $past(mem_o.addr) + 32'h2)
		else $error("memory words not consecutive");
	a_drain_first: assert property ($rose(mem_o.req) && mem_o.we |-> !$past(unit_busy_i))
		else $error("dump wrote while work outstanding");
	a_unavail_sine: assert property (s_cmd(`OPC_SINE, 1'b1) |=>
		fault_o.valid && fault_o.vec == `VEC_NM)
		else $error("unavailable fault missing");
	a_scale_once: assert property (s_cmd(`OPC_SCALE, 1'b0) |=>
		done_o && !busy_o && !fault_o.valid)
		else $error("exponent adjust not single cycle");
	a_busy_end: assert property ($fell(busy_o) |-> done_o)
		else $error("busy ended without done");
endmodule : fpu_state_chk

// ---- fpu_mem_model.sv ----
// memory partner of the fpu state unit: one 16-bit word per request
// assumes addresses below 64 KiB and a request held until ack
`timescale 1ns/10ps
module fpu_mem_model
	import fpu_unit_pkg::*;
(
	input wire logic clk_i, // clock
	input wire logic rstn_i, // reset, active low
	input wire mem_req_t mem_i, // request from the unit
	input wire logic slow_i, // answer after idle cycles
	output logic ack_o, // word taken or read data valid
	output logic [15:0] rdata_o, // read word
	output int n_wr_o // words written so far
);
	logic [15:0] mem [0:32767];
	logic [1:0] wait_q;
	// off an answer the bus shows the inverse, so a stale word never matches
	assign rdata_o = ack_o ? mem[mem_i.addr[15:1]] : ~mem[mem_i.addr[15:1]];
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ack_o <= 1'b0;
			wait_q <= 2'h0;
			n_wr_o <= 0;
		end else begin
			ack_o <= 1'b0;
			if (mem_i.req && ack_o) begin
				if (mem_i.we) begin
					mem[mem_i.addr[15:1]] <= mem_i.wdata;
					n_wr_o <= n_wr_o + 1;
				end
				wait_q <= 2'h0;
			end else if (mem_i.req) begin
				if (wait_q >= (slow_i ? 2'h2 : 2'h0))
					ack_o <= 1'b1;
				else
					wait_q <= wait_q + 2'h1;
			end
		end
	end
endmodule : fpu_mem_model

// ---- testbench.sv ----
// self-checking bench for the fpu state unit with its memory partner
// assumes the checker and memory model are compiled before this file
`timescale 1ns/10ps
`include "fpu_unit_regs.svh"
module testbench
	import fpu_unit_pkg::*;
;
	logic clk_i, rstn_i, reg_we_i, reg_re_i, prot_mode_i, v86_mode_i, align_check_i;
	logic wide_code_attr_i, seg_writable_i, coproc_absent_bit_i, task_switched_bit_i;
	logic unit_busy_i, intr_pending_i, mem_ack_i, fp_error_o, busy_o, done_o, slow;
	logic [1:0] cpl_i;
	logic [7:0] reg_addr_i;
	logic [15:0] mem_rdata_i, seed;
	logic [31:0] reg_wdata_i, reg_rdata_o, v;
	mem_req_t mem_o;
	fault_t fault_o, flt;
	logic [79:0] st_exp[8];
	logic [15:0] env[3] = '{16'h0c3f, 16'h4700, 16'h5555};
	logic [31:0] sc_in[5] = '{32'h4000_c000, 32'hc000_b000, 32'h3ffe_8000, 32'h4027_8000,
		32'hc027_8000};
	logic [31:0] sc_out[5] = '{32'h4002_8000, 32'h3ffd_8000, 32'h3fff_8000, 32'h7fff_8000, 0};
	logic [31:0] sn_in[4] = '{32'h403e_8000, 32'h3fd0_8000, 32'h3fff_8000, 32'h3fff_8000};
	logic [31:0] sn_hi[4] = '{32'h403e, 32'h3fd0, 32'h3ffe, 32'h3fff};
	logic [43:0] ft[8] = '{44'h4_d9fd_0000_07, 44'h2_d9fe_0000_07, 44'h4_db20_0000_07,
		44'h2_dd30_0000_07, 44'h0_dd30_ffd0_0d, 44'h0_db20_ffa3_0d, 44'h9_dd30_0100_0d,
		44'h8_db20_0101_11};
	int n_errors, compares, n_wr, n0, base, nw;

	fpu_state_unit i_fpu_state_unit(.*);
	fpu_mem_model i_fpu_mem_model(.clk_i(clk_i), .rstn_i(rstn_i), .mem_i(mem_o),
		.slow_i(slow), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i), .n_wr_o(n_wr));

	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	function automatic logic [31:0] mw(input int k);
		return {16'h0, i_fpu_mem_model.mem[k]};
	endfunction : mw
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_we_i <= 1'b1;
		@(posedge clk_i);
		reg_we_i <= 1'b0;
	endtask : wr
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_re_i <= 1'b1;
		@(posedge clk_i);
		reg_re_i <= 1'b0;
		#1 v = reg_rdata_o;
		chk(v, e);
	endtask : rchk
	task automatic cmd(input logic [31:0] op);
		int n;
		n = 0;
		wr(`REG_CMD, op);
		#1;
		while (done_o !== 1'b1 && n < 3000) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		flt = fault_o;
		if (n == 3000) n_errors++;
	endtask : cmd
	task automatic set_st(input int s, input logic [79:0] x);
		wr(`REG_SEL, s);
		wr(`REG_ST_LO, x[31:0]);
		wr(`REG_ST_MID, x[63:32]);
		wr(`REG_ST_HI, {16'h0, x[79:64]});
	endtask : set_st
	task automatic st_chk(input int s, input logic [79:0] x);
		wr(`REG_SEL, s);
		rchk(`REG_ST_LO, x[31:0]);
		rchk(`REG_ST_MID, x[63:32]);
		rchk(`REG_ST_HI, {16'h0, x[79:64]});
	endtask : st_chk
	task complete_run;
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : complete_run

	initial begin
		repeat (60000) @(posedge clk_i);
		n_errors++;
		complete_run;
	end

	initial begin
		{rstn_i, reg_we_i, reg_re_i, prot_mode_i, v86_mode_i, align_check_i, slow} = '0;
		{wide_code_attr_i, coproc_absent_bit_i, task_switched_bit_i, unit_busy_i} = '0;
		{intr_pending_i, cpl_i, reg_addr_i, reg_wdata_i} = '0;
		seg_writable_i = 1'b1;
		seed = 16'he49b;
		n_errors = 0;
		compares = 0;
		repeat (12) @(posedge clk_i);
		rstn_i <= 1'b1;
		rchk(`REG_FCW, 32'h037f);
		rchk(`REG_FTW, 32'hffff);
		rchk(8'hfc, 32'h0);
		for (int i = 0; i < 5; i++) begin
			set_st(0, 80'h3fff_8000_0000_0000_0000);
			set_st(1, {sc_in[i], 48'h0});
			cmd(32'hd9fd);
			st_chk(0, {sc_out[i], 48'h0});
			st_chk(1, {sc_in[i], 48'h0});
		end
		for (int i = 0; i < 4; i++) begin
			set_st(0, {sn_in[i], 48'h0});
			intr_pending_i <= (i == 3);
			cmd(32'hd9fe);
			@(posedge clk_i) intr_pending_i <= 1'b0;
			if (i < 3) rchk(`REG_FSW, {21'h0, i == 0, 10'h0});
			rchk(`REG_ST_HI, sn_hi[i]);
			rchk(`REG_STATUS, {30'h0, i == 3, 1'b0});
		end
		for (int w = 0; w < 2; w++) begin
			nw = w ? 54 : 47;
			base = 32'h100 << w;
			for (int i = 0; i < 8; i++) begin
				repeat (5) begin
					seed = lfsr(seed);
					st_exp[i] = {st_exp[i][63:0], seed};
				end
				set_st(i, st_exp[i]);
			end
			wr(`REG_FCW, 32'h0c3f);
			wr(`REG_FSW, 32'h4700);
			wr(`REG_FTW, 32'h5555);
			wr(`REG_OFFSET, base);
			{v86_mode_i, prot_mode_i, wide_code_attr_i, slow, unit_busy_i} <= {{4{w[0]}}, 1'b1};
			n0 = n_wr;
			fork
				cmd(32'hdd30);
				begin
					repeat (8) @(posedge clk_i);
					unit_busy_i <= 1'b0;
				end
			join
			chk(n_wr - n0, nw);
			// image is read only after done, so every word has landed
			for (int j = 0; j < 3; j++) chk(mw(base / 2 + j * (w + 1)), env[j]);
			for (int k = 0; k < 40; k++)
				chk(mw(base / 2 + nw - 40 + k), st_exp[k / 5][16 * (k % 5) +: 16]);
			rchk(`REG_FCW, 32'h037f);
			rchk(`REG_FSW, 32'h0);
			rchk(`REG_FTW, 32'hffff);
			cmd(32'hdb20);
			rchk(`REG_FCW, 32'h0c3f);
			rchk(`REG_FSW, 32'h4700);
			rchk(`REG_FTW, 32'h5555);
			for (int i = 0; i < 8; i++) st_chk(i, st_exp[i]);
		end
		i_fpu_mem_model.mem[base / 2] = 16'h0c3e;
		i_fpu_mem_model.mem[base / 2 + 2] = 16'h4701;
		cmd(32'hdb20);
		chk({31'h0, fp_error_o}, 32'h1);
		rchk(`REG_FSW, 32'hc781);
		n0 = n_wr;
		cmd(32'h1dd30);
		chk({23'h0, flt}, {23'h0, 1'b1, `VEC_MF});
		chk(n_wr - n0, 0);
		cmd(32'hdd30);
		chk(n_wr - n0, 54);
		chk({31'h0, fp_error_o}, 32'h0);
		n0 = n_wr;
		for (int i = 0; i < 8; i++) begin
			@(posedge clk_i);
			{prot_mode_i, coproc_absent_bit_i, task_switched_bit_i} <= ft[i][43:41];
			{seg_writable_i, v86_mode_i, wide_code_attr_i} <= {!ft[i][40], 2'h0};
			{cpl_i, align_check_i} <= 3'h7;
			wr(`REG_OFFSET, {16'h0, ft[i][23:8]});
			cmd({16'h0, ft[i][39:24]});
			chk({23'h0, flt}, {24'h1, ft[i][7:0]});
		end
		chk(n_wr - n0, 0);
		// an unknown opcode only raises the status flag and never signals done
		wr(`REG_CMD, 32'hd9ff);
		rchk(`REG_STATUS, 32'h0001_0000);
		complete_run;
	end
endmodule : testbench

bind fpu_state_unit fpu_state_chk i_fpu_state_chk(.*);
